/* File: src/ssm_socket_regs.sv */
// socket event, mask, present-state and force-event registers
// register map, byte offsets inside the socket window:
//   00 sticky event bits, write one to clear
//   04 interrupt enables, only bits 3:0 are kept
//   08 present state, read only
//   0c force event, write only, reads back zero
// force event layout:
//   3:0 set the matching event bits (lane 0)
//   13:10 set the matching card voltage bits (lane 1)
//   14 restarts card identification (lane 1)
//   31:29 replace the yy, xx and three-volt socket bits (lane 3)
// context state is the event bits, the enables, the card voltage
// bits and the socket overrides; the global reset always clears it,
// the pci reset pin only while power events are off.
// the pci reset pin is asynchronous and passes the synchroniser
// first, so its clear lands on the third edge after it rises.
// detect pins idle high; they pass the synchroniser inverted, so
// the zero held after reset reads as an empty slot and no false
// insertion or event follows reset.
// a hardware event and a software clear in one cycle leave the
// event set, so software never loses a change.
// apart from force writes and context clear, card voltage bits change only at the end of identification.
// detect level changes during identification stay hidden.
// detect enable codes 01 and 10 are treated as disabled.
// present-state bits 9:4 are not kept here and read zero.
// read data is registered: it appears one cycle after the read
// strobe and holds until the next read.
`timescale 1ns/1ps
`include "ssm_consts.svh"
module ssm_socket_regs
  import ssm_pkg::*;
#(
  parameter int PROBE_CYCLES = `SSM_PROBE_CYCLES
) (
  // clock and global reset
  input wire logic mclk,
  input wire logic rst,
  // pci reset pin and power management state
  input wire logic pciResetPin,
  input wire logic pmeEnable,
  // register port
  input wire logic [4:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [3:0] regByteEn,
  input wire logic [31:0] regWdata,
  output logic [31:0] regRdata,
  // socket pins
  input wire logic cardStatusLevelPin,
  input wire logic detectOneLevelPin,
  input wire logic detectTwoLevelPin,
  input wire logic [3:0] cardVoltSensePin,
  // same-clock inputs from power control and device control
  input wire logic socketPoweredFlag,
  input wire logic fiveVoltDisable,
  // interrupt and probe status
  output logic statusChangeInterrupt,
  output logic probeBusy
);
  // synchronised pins
  logic [7:0] pinsSync;
  logic pciResetSync;
  logic cardStatusLevel;
  logic detectOneSync;
  logic detectTwoSync;
  logic [3:0] voltSenseSync;

  // shown detect levels and card caps from the probe
  logic detectOneLevel;
  logic detectTwoLevel;
  logic [3:0] cardCaps;

  // register state
  ssm_event_t eventBits; // sticky socket events
  ssm_event_t next_eventBits;
  ssm_event_t maskBits; // interrupt enables
  ssm_event_t next_maskBits;
  logic [2:0] sockSupport; // yy, xx, three-volt support
  logic [2:0] next_sockSupport;
  ssm_event_t prevState; // present-state bits of the last cycle
  ssm_event_t next_prevState;
  logic [31:0] next_regRdata;
  logic next_statusChangeInterrupt;

  // decoded strobes
  logic contextClear;
  logic wrEvent;
  logic wrMask;
  logic wrForce;
  ssm_event_t liveState;
  ssm_event_t changed;
  logic [31:0] stateWord;
  logic socketSupportsFiveVolt;
  logic forceEvents; // force write on lane 0, sets event bits
  logic forceCard; // force write on lane 1, sets card voltage bits
  logic forceSocket; // force write on lane 3, replaces socket bits
  logic reprobe; // force write that restarts card identification
  // interrupt terms, one per enable field
  logic powerIrq; // power-cycle event enabled
  logic statusIrq; // card status event enabled
  logic detectIrq; // either detect event with the field at 11

  // address match for a register strobe
  function automatic logic hit(input logic [4:0] addr, input logic [4:0] ofs);
    hit = (addr == ofs);
  endfunction

  // pin synchronisers
  ssm_sync #(
    .WIDTH(8)
  ) u_pin_sync (
    .mclk(mclk),
    .rst(rst),
    .pinLevel({pciResetPin, cardStatusLevelPin, !detectOneLevelPin, !detectTwoLevelPin,
      cardVoltSensePin}),
    .syncLevel(pinsSync)
  );

  // bit order of the synchroniser: reset, status, detects, sense
  assign pciResetSync = pinsSync[7];
  assign cardStatusLevel = pinsSync[6];
  // detect pins travel inverted, so the reset zero means an empty slot
  assign detectOneSync = !pinsSync[5];
  assign detectTwoSync = !pinsSync[4];
  assign voltSenseSync = pinsSync[3:0];

  // context state falls to pci reset only while power events are off
  assign contextClear = pciResetSync && !pmeEnable;

  // write strobes
  assign wrEvent = regWrite && regByteEn[0] && hit(regAddr, `SSM_OFS_EVENT);
  assign wrMask = regWrite && regByteEn[0] && hit(regAddr, `SSM_OFS_MASK);
  assign wrForce = regWrite && hit(regAddr, `SSM_OFS_FORCE);

  // force register lanes
  assign forceEvents = wrForce && regByteEn[0];
  assign forceCard = wrForce && regByteEn[1];
  assign forceSocket = wrForce && regByteEn[3];
  assign reprobe = forceCard && regWdata[`SSM_FRC_REPROBE];

  // card identification sequencer
  ssm_card_probe #(
    .PROBE_CYCLES(PROBE_CYCLES)
  ) u_probe (
    .mclk(mclk),
    .rst(rst),
    .contextClear(contextClear),
    .detectOneSync(detectOneSync),
    .detectTwoSync(detectTwoSync),
    .voltSenseSync(voltSenseSync),
    .reprobe(reprobe),
    .forceCardWrite(forceCard),
    .forceCardBits(regWdata[`SSM_FRC_CARD_LSB +: 4]),
    .probeBusy(probeBusy),
    .detectOneShown(detectOneLevel),
    .detectTwoShown(detectTwoLevel),
    .cardCaps(cardCaps)
  );

  // live low nibble of the present state
  always_comb begin
    liveState = '0;
    liveState[`SSM_ST_CSTS] = cardStatusLevel;
    liveState[`SSM_ST_CD1] = detectOneLevel;
    liveState[`SSM_ST_CD2] = detectTwoLevel;
    // the power flag is same-clock logic and needs no synchroniser
    liveState[`SSM_ST_PWR] = socketPoweredFlag;
  end

  assign changed = liveState ^ prevState;
  assign socketSupportsFiveVolt = !fiveVoltDisable;

  // full present-state word, reserved fields zero
  always_comb begin
    stateWord = 32'h0000_0000;
    stateWord[`SSM_ST_SOCK_LSB +: 4] = {sockSupport, socketSupportsFiveVolt};
    stateWord[`SSM_ST_CARD_LSB +: 4] = cardCaps;
    stateWord[3:0] = liveState;
  end

  // event bits: hardware set wins over software clear
  always_comb begin
    next_eventBits = eventBits;
    // write one to clear, applied before any set
    if (wrEvent) begin
      next_eventBits = eventBits & ~regWdata[3:0];
    end
    // a change of the present state sets its bit, mask or not
    next_eventBits = next_eventBits | changed;
    // force writes set bits too
    if (forceEvents) begin
      next_eventBits = next_eventBits | regWdata[3:0];
    end
    // context clear overrides everything
    if (contextClear) begin
      next_eventBits = `SSM_EVENT_RESET;
    end
  end

  // mask bits
  always_comb begin
    next_maskBits = maskBits;
    // lane 0 write replaces all four enables
    if (wrMask) begin
      next_maskBits = regWdata[3:0];
    end
    // context clear from the pci reset pin
    if (contextClear) begin
      next_maskBits = `SSM_MASK_RESET;
    end
  end

  // socket support overrides written through force event
  always_comb begin
    next_sockSupport = sockSupport;
    // lane 3 write replaces the three override bits
    if (forceSocket) begin
      next_sockSupport = regWdata[`SSM_FRC_SOCK_LSB +: 3];
    end
    // back to three-volt support only
    if (contextClear) begin
      next_sockSupport = `SSM_SOCK_RESET;
    end
  end

  // last-cycle present state for change detection
  always_comb begin
    // the nibble of the last cycle; any difference is an event
    next_prevState = liveState;
  end

  // interrupt: any set event whose enable is on
  always_comb begin
    powerIrq = eventBits[`SSM_EV_PWR] && maskBits[`SSM_EV_PWR];
    statusIrq = eventBits[`SSM_EV_CSTS] && maskBits[`SSM_EV_CSTS];
    // one enable field covers both detect events; 01 and 10 count as off
    detectIrq = (eventBits[`SSM_EV_CD1] || eventBits[`SSM_EV_CD2]) &&
      (maskBits[2:1] == `SSM_CD_ENABLED);
    next_statusChangeInterrupt = powerIrq || statusIrq || detectIrq;
  end

  // read data mux, registered one cycle after the read strobe
  always_comb begin
    // hold the last word while no read is taken
    next_regRdata = regRdata;
    if (regRead) begin
      case (regAddr)
        `SSM_OFS_EVENT: begin
          // sticky events in the low nibble
          next_regRdata = {28'h000_0000, eventBits};
        end
        `SSM_OFS_MASK: begin
          // enables in the low nibble, reserved bits zero
          next_regRdata = {28'h000_0000, maskBits};
        end
        `SSM_OFS_STATE: begin
          // live levels, card bits and socket support
          next_regRdata = stateWord;
        end
        default: begin
          // force event is write-only; unmapped offsets read zero
          next_regRdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // register event, mask, override, history and outputs
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      eventBits <= `SSM_EVENT_RESET;
      maskBits <= `SSM_MASK_RESET;
      sockSupport <= `SSM_SOCK_RESET;
      prevState <= `SSM_STATE_RESET; // matches the live nibble after reset
      regRdata <= 32'h0000_0000;
      statusChangeInterrupt <= 1'b0;
    end else begin
      eventBits <= next_eventBits;
      maskBits <= next_maskBits;
      sockSupport <= next_sockSupport;
      prevState <= next_prevState;
      regRdata <= next_regRdata;
      statusChangeInterrupt <= next_statusChangeInterrupt;
    end
  end
endmodule

/* File: src/ssm_consts.svh */
// offsets, field positions, reset values and timing counts of the socket status block
`ifndef SSM_CONSTS_SVH
`define SSM_CONSTS_SVH

// register byte offsets inside the socket window
`define SSM_OFS_EVENT 5'h00
`define SSM_OFS_MASK 5'h04
`define SSM_OFS_STATE 5'h08
`define SSM_OFS_FORCE 5'h0c

// event and mask field positions
`define SSM_EV_CSTS 0
`define SSM_EV_CD1 1
`define SSM_EV_CD2 2
`define SSM_EV_PWR 3
`define SSM_EV_WIDTH 4

// present-state field positions
`define SSM_ST_CSTS 0
`define SSM_ST_CD1 1
`define SSM_ST_CD2 2
`define SSM_ST_PWR 3
`define SSM_ST_CARD_LSB 10
`define SSM_ST_SOCK_LSB 28

// force-event field positions
`define SSM_FRC_CARD_LSB 10
`define SSM_FRC_REPROBE 14
`define SSM_FRC_SOCK_LSB 29

// reset values
`define SSM_MASK_RESET 4'h0
`define SSM_EVENT_RESET 4'h0
`define SSM_SOCK_RESET 3'h1
`define SSM_CARD_RESET 4'h0
// live present-state nibble of an empty, unpowered slot
`define SSM_STATE_RESET 4'h6
`define SSM_CD_ENABLED 2'h3

// card identification time, in ns, and its length in cycles of a 100 MHz clock
`define SSM_CLK_PERIOD_NS 10
`define SSM_PROBE_TIME_NS 160
`define SSM_PROBE_CYCLES ((`SSM_PROBE_TIME_NS + `SSM_CLK_PERIOD_NS - 1) / `SSM_CLK_PERIOD_NS)

`endif

/* File: src/ssm_pkg.sv */
// types shared by the socket status block
package ssm_pkg;
  // card identification sequencer states
  typedef enum logic [0:0] {
    SSM_PROBE_IDLE = 1'b0,
    SSM_PROBE_RUN = 1'b1
  } ssm_probe_state_t;

  // event or mask vector
  typedef logic [3:0] ssm_event_t;
endpackage

/* File: src/ssm_sync.sv */
// two-flop synchroniser for socket pins
`timescale 1ns/1ps
module ssm_sync
  import ssm_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // pin side
  input wire logic [WIDTH-1:0] pinLevel,
  // clock side
  output logic [WIDTH-1:0] syncLevel
);
  logic [WIDTH-1:0] stageOne; // first stage, read only by the second
  logic [WIDTH-1:0] next_stageOne;
  logic [WIDTH-1:0] next_syncLevel;

  // next values of both stages
  always_comb begin
    next_stageOne = pinLevel;
    next_syncLevel = stageOne;
  end

  // register both stages
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stageOne <= '0;
      syncLevel <= '0;
    end else begin
      stageOne <= next_stageOne;
      syncLevel <= next_syncLevel;
    end
  end
endmodule

/* File: src/ssm_card_probe.sv */
// card identification: freezes detect levels while probing, latches card voltage support
`timescale 1ns/1ps
`include "ssm_consts.svh"
module ssm_card_probe
  import ssm_pkg::*;
#(
  parameter int PROBE_CYCLES = `SSM_PROBE_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // synchronous clear of the context state
  input wire logic contextClear,
  // synchronised socket levels
  input wire logic detectOneSync,
  input wire logic detectTwoSync,
  input wire logic [3:0] voltSenseSync,
  // software requests
  input wire logic reprobe,
  input wire logic forceCardWrite,
  input wire logic [3:0] forceCardBits,
  // results
  output logic probeBusy,
  output logic detectOneShown,
  output logic detectTwoShown,
  output logic [3:0] cardCaps
);
  localparam int CW = $clog2(PROBE_CYCLES + 1);

  ssm_probe_state_t state;
  ssm_probe_state_t next_state;
  logic [CW-1:0] count; // cycles left in the probe
  logic [CW-1:0] next_count;
  logic wasPresent; // card seen present in the previous cycle
  logic next_wasPresent;
  logic next_detectOneShown;
  logic next_detectTwoShown;
  logic [3:0] next_cardCaps;
  logic present;

  assign present = !detectOneSync && !detectTwoSync;
  assign probeBusy = (state == SSM_PROBE_RUN);

  // sequencer, shown detect levels and card capability latch
  always_comb begin
    next_state = state;
    next_count = count;
    next_wasPresent = present;
    next_detectOneShown = detectOneShown;
    next_detectTwoShown = detectTwoShown;
    next_cardCaps = cardCaps;
    case (state)
      SSM_PROBE_IDLE: begin
        // detect levels follow the pins outside a probe
        next_detectOneShown = detectOneSync;
        next_detectTwoShown = detectTwoSync;
        if ((present && !wasPresent) || reprobe) begin
          next_state = SSM_PROBE_RUN;
          next_count = CW'(PROBE_CYCLES);
        end
      end
      SSM_PROBE_RUN: begin
        // detect changes during the probe stay hidden
        next_count = count - CW'(1);
        if (count == CW'(1)) begin
          next_state = SSM_PROBE_IDLE;
          next_cardCaps = present ? voltSenseSync : `SSM_CARD_RESET;
          next_detectOneShown = detectOneSync;
          next_detectTwoShown = detectTwoSync;
        end
      end
      default: begin
        next_state = SSM_PROBE_IDLE;
      end
    endcase
    // software force sets card support bits
    if (forceCardWrite) begin
      next_cardCaps = next_cardCaps | forceCardBits;
    end
    if (contextClear) begin
      next_cardCaps = `SSM_CARD_RESET;
    end
  end

  // register the sequencer
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= SSM_PROBE_IDLE;
      count <= '0;
      wasPresent <= 1'b0;
      detectOneShown <= 1'b1;
      detectTwoShown <= 1'b1;
      cardCaps <= `SSM_CARD_RESET;
    end else begin
      state <= next_state;
      count <= next_count;
      wasPresent <= next_wasPresent;
      detectOneShown <= next_detectOneShown;
      detectTwoShown <= next_detectTwoShown;
      cardCaps <= next_cardCaps;
    end
  end
endmodule

/* File: dv/ssm_card_model.sv */
// card in the socket: drives detect, status and voltage sense pins
`timescale 1ns/1ps
module ssm_card_model #(
  parameter int LAG = 2
) (
  // clock for the delayed second contact
  input wire logic mclk,
  // what the card does
  input wire logic present,
  input wire logic statusOut,
  input wire logic [3:0] caps,
  // socket pins
  output logic detectOne,
  output logic detectTwo,
  output logic cardStatus,
  output logic [3:0] voltSense
);
  // insertion history, so the second contact closes later
  logic [7:0] seen = 8'h00;
  always @(posedge mclk) begin
    seen <= {seen[6:0], present};
  end
  // detect pins are pulled up when the slot is empty
  assign detectOne = !present;
  assign detectTwo = !seen[LAG];
  // status pin pulled low with no card
  assign cardStatus = present & statusOut;
  // sense pins float high with no card
  assign voltSense = present ? caps : 4'hf;
endmodule

/* File: dv/ssm_socket_regs_props.sv */
// port assertions for the socket status block
`timescale 1ns/1ps
module ssm_socket_regs_props (
  // clock and resets
  input wire logic mclk,
  input wire logic rst,
  input wire logic pciResetPin,
  input wire logic pmeEnable,
  // register port
  input wire logic [4:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [3:0] regByteEn,
  input wire logic [31:0] regWdata,
  input wire logic [31:0] regRdata,
  // socket and device side
  input wire logic cardStatusLevelPin,
  input wire logic detectOneLevelPin,
  input wire logic detectTwoLevelPin,
  input wire logic [3:0] cardVoltSensePin,
  input wire logic socketPoweredFlag,
  input wire logic fiveVoltDisable,
  // outputs
  input wire logic statusChangeInterrupt,
  input wire logic probeBusy
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // how long the status pin has held its level, saturating
  logic csPrev;
  logic next_csPrev;
  logic [2:0] csHeld;
  logic [2:0] next_csHeld;
  always_comb begin
    next_csPrev = cardStatusLevelPin;
    next_csHeld = (csHeld == 3'h7) ? csHeld : csHeld + 3'h1;
    if (cardStatusLevelPin != csPrev) begin
      next_csHeld = 3'h0;
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      csPrev <= 1'b0;
      csHeld <= 3'h0;
    end else begin
      csPrev <= next_csPrev;
      csHeld <= next_csHeld;
    end
  end
  reset_clear_a: assert property ($fell(rst) |-> regRdata == 32'h0000_0000
    && !statusChangeInterrupt && !probeBusy) else $error("outputs not clear after reset");
  dead_addr_a: assert property (regRead && regAddr >= 5'h0c
    |=> regRdata == 32'h0000_0000) else $error("unmapped read not zero");
  mask_rsvd_a: assert property (regRead && regAddr == 5'h04
    |=> regRdata[31:4] == 28'h000_0000) else $error("mask upper bits not zero");
  state_rsvd_a: assert property (regRead && regAddr == 5'h08
    |=> regRdata[27:14] == 14'h0000) else $error("state reserved bits not zero");
  five_volt_a: assert property (regRead && regAddr == 5'h08 && $stable(fiveVoltDisable)
    |=> regRdata[28] == !$past(fiveVoltDisable)) else $error("five volt bit wrong");
  irq_sticky_a: assert property (statusChangeInterrupt && pmeEnable && !regWrite
    && !$past(regWrite) |=> statusChangeInterrupt) else $error("interrupt dropped alone");
  mask_echo_a: assert property (regWrite && regAddr == 5'h04 && regByteEn[0]
    ##2 regRead && regAddr == 5'h04
    |=> ((regRdata ^ $past(regWdata, 3)) & 32'h0000_000f) == 32'h0000_0000)
    else $error("mask readback wrong");
  card_status_a: assert property (regRead && regAddr == 5'h08 && csHeld >= 3'h5
    |=> regRdata[0] == $past(cardStatusLevelPin)) else $error("status level wrong");
  probe_bound_a: assert property ($rose(probeBusy) |-> ##[1:40] !probeBusy)
    else $error("identification never ends");
endmodule

/* File: dv/ssm_socket_regs_test.sv */
// register-level bench for the socket status block
`timescale 1ns/1ps
module ssm_socket_regs_test;
  // clock, resets and side controls
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic pciResetPin = 1'b0;
  logic pmeEnable = 1'b0;
  logic socketPoweredFlag = 1'b0;
  logic fiveVoltDisable = 1'b0;
  // register port
  logic [4:0] regAddr = 5'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [3:0] regByteEn = 4'h0;
  logic [31:0] regWdata = 32'h0000_0000;
  logic [31:0] regRdata;
  logic [31:0] rdat;
  // card behaviour and socket pins
  logic present = 1'b0;
  logic statusOut = 1'b0;
  logic [3:0] caps = 4'h5;
  logic cardStatusPin;
  logic detectOnePin;
  logic detectTwoPin;
  logic [3:0] voltSensePin;
  logic statusChangeInterrupt;
  logic probeBusy;
  int failCount = 0;
  int compares = 0;
  int cycles = 0;
  initial begin
    forever #5 mclk = ~mclk;
  end
  ssm_card_model i_ssm_card_model (.mclk(mclk), .present(present), .statusOut(statusOut),
    .caps(caps), .detectOne(detectOnePin), .detectTwo(detectTwoPin),
    .cardStatus(cardStatusPin), .voltSense(voltSensePin));
  ssm_socket_regs #(.PROBE_CYCLES(8)) i_ssm_socket_regs (.mclk(mclk), .rst(rst),
    .pciResetPin(pciResetPin), .pmeEnable(pmeEnable), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead), .regByteEn(regByteEn), .regWdata(regWdata),
    .regRdata(regRdata), .cardStatusLevelPin(cardStatusPin),
    .detectOneLevelPin(detectOnePin), .detectTwoLevelPin(detectTwoPin),
    .cardVoltSensePin(voltSensePin), .socketPoweredFlag(socketPoweredFlag),
    .fiveVoltDisable(fiveVoltDisable), .statusChangeInterrupt(statusChangeInterrupt),
    .probeBusy(probeBusy));
  // verdict and end of run
  task automatic wrapUp;
    $display("checks %0d, mismatches %0d", compares, failCount);
    if (failCount == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      failCount++;
      wrapUp();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // one write cycle
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regByteEn <= be;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask
  // one read cycle; data lands the edge after the strobe
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    @(negedge mclk);
    d = regRdata;
    @(posedge mclk);
  endtask
  task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failCount++;
      $display("unexpected at %0t: read %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic chkBit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      failCount++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  endtask
  // read and compare the bits under m
  task automatic rdChk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a, rdat);
    chkReg(rdat & m, e);
  endtask
  initial begin
    tick(12);
    rst <= 1'b0;
    tick(6);
    wr(5'h00, 32'h0000_000f, 4'h1);
    rdChk(5'h04, 32'hffff_ffff, 32'h0000_0000);
    rdChk(5'h08, 32'hffff_c000, 32'h3000_0000);
    wr(5'h04, 32'hffff_ffff, 4'hf);
    rdChk(5'h04, 32'hffff_ffff, 32'h0000_000f);
    wr(5'h04, 32'h0000_0000, 4'hf);
    socketPoweredFlag <= 1'b1;
    tick(8);
    chkBit(statusChangeInterrupt, 1'b0);
    rdChk(5'h00, 32'hffff_ffff, 32'h0000_0008);
    wr(5'h04, 32'h0000_0008, 4'h1);
    tick(3);
    chkBit(statusChangeInterrupt, 1'b1);
    wr(5'h00, 32'h0000_0008, 4'h1);
    tick(3);
    chkBit(statusChangeInterrupt, 1'b0);
    wr(5'h04, 32'h0000_0002, 4'h1);
    present <= 1'b1;
    tick(30);
    chkBit(statusChangeInterrupt, 1'b0);
    rdChk(5'h08, 32'h0000_3c0f, 32'h0000_1408);
    rdChk(5'h00, 32'h0000_000f, 32'h0000_0006);
    wr(5'h04, 32'h0000_0006, 4'h1);
    tick(3);
    chkBit(statusChangeInterrupt, 1'b1);
    wr(5'h00, 32'h0000_000f, 4'h1);
    caps <= 4'ha;
    statusOut <= 1'b1;
    wr(5'h04, 32'h0000_0001, 4'h1);
    tick(8);
    chkBit(statusChangeInterrupt, 1'b1);
    rdChk(5'h08, 32'h0000_3c01, 32'h0000_1401);
    wr(5'h0c, 32'h0000_2000, 4'h2);
    rdChk(5'h08, 32'h0000_3c00, 32'h0000_3400);
    rdChk(5'h0c, 32'hffff_ffff, 32'h0000_0000);
    wr(5'h0c, 32'he000_0000, 4'h8);
    rdChk(5'h08, 32'he000_0000, 32'he000_0000);
    fiveVoltDisable <= 1'b1;
    tick(2);
    rdChk(5'h08, 32'h1000_0000, 32'h0000_0000);
    wr(5'h0c, 32'h0000_4000, 4'h2);
    present <= 1'b0;
    tick(3);
    chkBit(probeBusy, 1'b1);
    rdChk(5'h08, 32'h0000_0006, 32'h0000_0000);
    tick(16);
    rdChk(5'h08, 32'h0000_0006, 32'h0000_0006);
    wr(5'h04, 32'h0000_000f, 4'h1);
    pmeEnable <= 1'b1;
    pciResetPin <= 1'b1;
    tick(5);
    pciResetPin <= 1'b0;
    tick(2);
    rdChk(5'h04, 32'h0000_000f, 32'h0000_000f);
    pmeEnable <= 1'b0;
    pciResetPin <= 1'b1;
    tick(5);
    pciResetPin <= 1'b0;
    tick(2);
    rdChk(5'h04, 32'h0000_000f, 32'h0000_0000);
    rdChk(5'h00, 32'h0000_000f, 32'h0000_0000);
    wr(5'h0c, 32'h0000_0008, 4'h1);
    rdChk(5'h00, 32'h0000_000f, 32'h0000_0008);
    wrapUp();
  end
endmodule
bind ssm_socket_regs ssm_socket_regs_props i_ssm_socket_regs_props (.mclk(mclk), .rst(rst),
  .pciResetPin(pciResetPin), .pmeEnable(pmeEnable), .regAddr(regAddr),
  .regWrite(regWrite), .regRead(regRead), .regByteEn(regByteEn), .regWdata(regWdata),
  .regRdata(regRdata), .cardStatusLevelPin(cardStatusLevelPin),
  .detectOneLevelPin(detectOneLevelPin), .detectTwoLevelPin(detectTwoLevelPin),
  .cardVoltSensePin(cardVoltSensePin), .socketPoweredFlag(socketPoweredFlag),
  .fiveVoltDisable(fiveVoltDisable), .statusChangeInterrupt(statusChangeInterrupt),
  .probeBusy(probeBusy));
